// [core/chc_top.sv]
// chc_top: strap detection, charge phase sequencer, safety timers, AXI4-Lite slave
// assumes pin readings and comparator results are synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module chc_top
    import chc_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // supply, enable, strap readings and comparator results
    input  wire logic              power_good,
    input  wire logic              charge_enable_n,
    input  wire logic [4:0]        charge_current_set_pin,
    input  wire logic [4:0]        chemistry_timer_select_pin,
    input  wire logic [4:0]        regulation_voltage_select_pin,
    input  wire chc_pkg::chc_sense_s sense,
    // regulator drive and status
    output chc_pkg::chc_drive_s    drive,
    output logic                   fault,
    output logic                   charge_done,
    // AXI4-Lite slave
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import chc_pkg::*;

    chc_state_e  state;
    chc_state_e  next_state;
    logic        run_ok;
    logic        soft_disable;
    logic        is_nimh;
    logic [4:0]  timer_hours;
    logic [4:0]  regulation_voltage_select_pin_code;
    logic        intermittent;
    logic [16:0] tmr;
    logic [16:0] tmr_limit;
    logic [16:0] next_limit;
    logic        tmr_expired;
    logic        half;
    logic        tick;
    logic [23:0] div;
    logic        lowv_q;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;

    // hours from a chemistry code; zero means no timer
    function automatic logic [4:0] chem_hours(input logic [4:0] c);
        if (c == CT_LI_5H) begin
            return LI_HR_SHORT;
        end else if (c == CT_LI_10H) begin
            return LI_HR_LONG;
        end else if (c >= CT_NIMH_4H && c < PIN_SHORT) begin
            return 5'(NIMH_HR_BASE + ((c - CT_NIMH_4H) << 1));
        end
        return 5'h00;
    endfunction

    function automatic logic [16:0] hours_to_ticks(input logic [4:0] h);
        return 17'(int'(h) * SEC_PER_HR / TICK_S);
    endfunction

    // supply, enable and soft_disable gate the sequencer, a toggle of any of them restarts detection
    assign run_ok = power_good && !charge_enable_n && !soft_disable;

    // timebase tick, one pulse per second
    always_ff @(posedge sys_clk) begin
        if (!rst_n || div == 24'(TICK_DIV - 1)) begin
            div <= 24'h00_0000;
        end else begin
            div <= div + 24'h00_0001;
        end
    end
    assign tick = (div == 24'(TICK_DIV - 1));

    assign tmr_expired = (tmr_limit != 17'h0_0000) && (tmr >= tmr_limit);

    always_comb begin
        next_state = state;
        next_limit = tmr_limit;
        if (!run_ok) begin
            next_state = CHC_IDLE;
        end else begin
            unique case (state)
                CHC_IDLE: next_state = CHC_DET_CUR;
                CHC_DET_CUR: next_state = (charge_current_set_pin == PIN_SHORT) ? CHC_FAULT : CHC_DET_CHEM;
                CHC_DET_CHEM: begin
                    if (chemistry_timer_select_pin == PIN_SHORT || chemistry_timer_select_pin == PIN_OPEN) begin
                        next_state = CHC_FAULT;
                    end else if (chemistry_timer_select_pin == CT_MARGIN) begin
                        next_state = CHC_NOCHG;
                    end else begin
                        next_state = CHC_DET_VOLT;
                    end
                end
                // two lowest codes (1 and 2, below VS_NIMH_MIN) no charge in NiMH
                CHC_DET_VOLT: begin
                    if (regulation_voltage_select_pin == PIN_SHORT || regulation_voltage_select_pin == PIN_OPEN) begin
                        next_state = CHC_NOCHG;
                    end else if (is_nimh && regulation_voltage_select_pin < VS_NIMH_MIN) begin
                        next_state = CHC_NOCHG;
                    end else begin
                        next_state = CHC_START;
                    end
                end
                CHC_START: begin
                    if (is_nimh) begin
                        next_state = CHC_NIMH_WAIT;
                    end else if (sense.below_lowv) begin
                        next_state = CHC_PRE;
                        next_limit = PRECHG_TICKS;
                    end else begin
                        next_state = CHC_FAST;
                        next_limit = hours_to_ticks(timer_hours);
                    end
                end
                CHC_PRE: begin
                    if (tmr_expired) begin
                        next_state = CHC_DONE;
                    end else if (!sense.below_lowv) begin
                        next_state = CHC_FAST;
                        next_limit = hours_to_ticks(timer_hours);
                    end
                end
                CHC_FAST, CHC_CV: begin
                    if (tmr_expired) begin
                        next_state = CHC_DONE;
                    end else if (sense.below_lowv) begin
                        next_state = CHC_PRE;
                        next_limit = PRECHG_TICKS;
                    end else if (state == CHC_FAST && sense.at_vreg) begin
                        next_state = CHC_CV;
                    end else if (state == CHC_CV && sense.below_term && !sense.below_rechg && !sense.thermal_reg) begin
                        next_state = CHC_STANDBY;
                    end
                end
                CHC_STANDBY: next_state = sense.below_rechg ? CHC_START : CHC_STANDBY;
                CHC_NIMH_WAIT: begin
                    if (sense.below_rechg) begin
                        next_state = CHC_NIMH_CC;
                        next_limit = hours_to_ticks(timer_hours);
                    end
                end
                // NiMH end on timer or overvoltage
                CHC_NIMH_CC: begin
                    if (tmr_expired || sense.above_ovp) begin
                        next_state = intermittent ? CHC_NIMH_IWAIT : CHC_DONE;
                    end
                end
                CHC_NIMH_IWAIT: begin
                    if (sense.below_rechg) begin
                        next_state = CHC_NIMH_CC;
                        next_limit = hours_to_ticks(timer_hours) >> INTER_SHIFT;
                    end
                end
                CHC_DONE, CHC_NOCHG, CHC_FAULT: next_state = state;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state     <= CHC_IDLE;
            tmr_limit <= 17'h0_0000;
        end else begin
            state     <= next_state;
            tmr_limit <= next_limit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || state == CHC_IDLE) begin
            is_nimh      <= 1'b0;
            timer_hours  <= 5'h00;
            regulation_voltage_select_pin_code    <= 5'h00;
            intermittent <= 1'b0;
        end else if (state == CHC_DET_CHEM) begin
            is_nimh     <= chemistry_timer_select_pin >= CT_NIMH_4H;
            timer_hours <= chem_hours(chemistry_timer_select_pin);
        end else if (state == CHC_DET_VOLT) begin
            regulation_voltage_select_pin_code    <= regulation_voltage_select_pin;
            intermittent <= is_nimh && !regulation_voltage_select_pin[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || next_state != state) begin
            tmr  <= 17'h0_0000;
            half <= 1'b0;
        end else if (tick && (state == CHC_PRE || state == CHC_FAST || state == CHC_CV || state == CHC_NIMH_CC)) begin
            half <= sense.thermal_reg ? !half : 1'b0;
            if (!sense.thermal_reg || half) begin
                tmr <= tmr + 17'h0_0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drive       <= '0;
            fault       <= 1'b0;
            charge_done <= 1'b0;
        end else begin
            drive.enable       <= state inside {CHC_PRE, CHC_FAST, CHC_CV, CHC_NIMH_CC};
            drive.volt_loop    <= state == CHC_CV;
            drive.current_code <= (charge_current_set_pin == PIN_SHORT) ? PIN_OPEN : charge_current_set_pin;
            drive.current_pct  <= (state == CHC_PRE) ? PRE_PCT : FULL_PCT;
            drive.vreg_code    <= regulation_voltage_select_pin_code;
            fault              <= state == CHC_FAULT;
            charge_done        <= state inside {CHC_DONE, CHC_STANDBY, CHC_NIMH_IWAIT};
        end
    end

    // AXI4-Lite: address and data taken in either order, response after both
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            soft_disable  <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            // ready is a flop, so it reopens one cycle after the response is taken
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end else if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
                if (aw_addr == REG_CTRL && s_axi_wstrb[0]) begin
                    soft_disable <= w_data[0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
        end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL:   s_axi_rdata <= {31'h0000_0000, soft_disable};
                REG_STATUS: s_axi_rdata <= {24'h00_0000, fault, charge_done, is_nimh, intermittent, state};
                REG_CONFIG: s_axi_rdata <= {17'h0_0000, TERM_PCT[4:0], timer_hours, regulation_voltage_select_pin_code};
                REG_TIMER:  s_axi_rdata <= {15'h0000, tmr};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end

    // checks
    chk_fault_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == CHC_FAULT && run_ok |=> state == CHC_FAULT)
        else $error("fault released without restart");
    chk_detect_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == CHC_START |-> $past(state) == CHC_DET_VOLT || $past(state) == CHC_STANDBY)
        else $error("charger started out of order");
    chk_detect_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !power_good || charge_enable_n |=> state == CHC_IDLE)
        else $error("detection without supply and enable");
    chk_cur_short: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == CHC_DET_CUR && charge_current_set_pin == PIN_SHORT && run_ok |=> state == CHC_FAULT ##1 fault)
        else $error("current short not faulted");
    chk_cur_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        charge_current_set_pin != PIN_SHORT |=> drive.current_code == $past(charge_current_set_pin))
        else $error("current code not followed");
    chk_chem_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state inside {CHC_FAST, CHC_CV, CHC_NIMH_CC} && $past(state) == state |-> $stable(timer_hours))
        else $error("chemistry setting changed while running");
    chk_pre_pct: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == CHC_PRE |=> drive.current_pct == PRE_PCT && drive.enable)
        else $error("precharge current wrong");
    chk_pre_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == CHC_PRE |-> tmr_limit == PRECHG_TICKS)
        else $error("precharge limit wrong");
    chk_expiry_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        run_ok && tmr_expired && state inside {CHC_PRE, CHC_FAST, CHC_CV} |=> state == CHC_DONE ##1 !drive.enable)
        else $error("expiry did not end charge");
    chk_half_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick && sense.thermal_reg && !half && next_state == state |=> $stable(tmr))
        else $error("timer counted at full rate");
endmodule
`default_nettype wire

// [core/chc_pkg.sv]
// chc_pkg: constants, states and carriers for the charger control block
// assumes a 10 MHz system clock and coded readings of the three strap resistors
package chc_pkg;
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          TICK_S       = 1;
    localparam int          TICK_CYCLES  = CLK_HZ * TICK_S;
    localparam int          PRECHG_MIN   = 30;
    localparam int          SEC_PER_MIN  = 60;
    localparam int          SEC_PER_HR   = 3600;
    localparam logic [16:0] PRECHG_TICKS = 17'(PRECHG_MIN * SEC_PER_MIN / TICK_S);
    localparam logic [6:0]  PRE_PCT      = 7'h14;
    localparam logic [6:0]  FULL_PCT     = 7'h64;
    localparam logic [6:0]  TERM_PCT     = 7'h0A;
    localparam int          INTER_SHIFT  = 2;
    // pin codes: 0 open, 1..14 table rows from 100k down to 3.6k, 15 unused, 16 short
    localparam logic [4:0]  PIN_OPEN     = 5'h00;
    localparam logic [4:0]  PIN_SHORT    = 5'h10;
    localparam logic [4:0]  CT_LI_5H     = 5'h01;
    localparam logic [4:0]  CT_LI_10H    = 5'h02;
    localparam logic [4:0]  CT_LI_NOTMR  = 5'h03;
    localparam logic [4:0]  CT_MARGIN    = 5'h04;
    localparam logic [4:0]  CT_NIMH_4H   = 5'h05;
    localparam logic [4:0]  VS_NIMH_MIN  = 5'h03;
    localparam logic [4:0]  LI_HR_SHORT  = 5'h05;
    localparam logic [4:0]  LI_HR_LONG   = 5'h0A;
    localparam logic [4:0]  NIMH_HR_BASE = 5'h04;
    // register byte addresses
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_CONFIG   = 4'h8;
    localparam logic [3:0]  REG_TIMER    = 4'hC;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [3:0] {
        CHC_IDLE, CHC_DET_CUR, CHC_DET_CHEM, CHC_DET_VOLT, CHC_START,
        CHC_PRE, CHC_FAST, CHC_CV, CHC_STANDBY, CHC_NIMH_WAIT, CHC_NIMH_CC,
        CHC_NIMH_IWAIT, CHC_DONE, CHC_NOCHG, CHC_FAULT
    } chc_state_e;

    // analog comparator results from the battery side
    typedef struct packed {
        logic below_lowv;
        logic below_rechg;
        logic above_ovp;
        logic at_vreg;
        logic below_term;
        logic thermal_reg;
    } chc_sense_s;

    // drive to the regulator
    typedef struct packed {
        logic       enable;
        logic       volt_loop;
        logic [4:0] current_code;
        logic [6:0] current_pct;
        logic [4:0] vreg_code;
    } chc_drive_s;
endpackage

// [verif/chc_batt.sv]
// chc_batt: battery pack seen by the charger, as comparator levels
// assumes the bench sets the cell condition between checks
`timescale 1ns/10ps
`default_nettype none
module chc_batt
    import chc_pkg::*;
(
    // cell condition from the bench
    input  wire logic                lowv,
    input  wire logic                sag,
    input  wire logic                over,
    input  wire logic                hot,
    // regulator drive and comparator results
    input  wire chc_pkg::chc_drive_s drive,
    output var  chc_pkg::chc_sense_s sense
);
    // current only tapers under the voltage loop, so termination cannot come early
    assign sense = '{below_lowv: lowv, below_rechg: sag, above_ovp: over,
        at_vreg: !lowv && !sag, below_term: drive.volt_loop && !sag, thermal_reg: hot};
endmodule
`default_nettype wire

// [verif/charger_config_and_phase_control_tb_top.sv]
// charger_config_and_phase_control_tb_top: strap, phase and register checks
// assumes chc_batt as the pack and a 4-cycle timer tick
`timescale 1ns/10ps
`default_nettype none
module charger_config_and_phase_control_tb_top;
    import chc_pkg::*;
    logic        sys_clk, rst_n, power_good, en_n, lowv, sag, over, hot, fault, done;
    logic [4:0]  cur, chem, volt;
    chc_sense_s  sense;
    chc_drive_s  drive;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d, t0;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, r;
    int          errors, comparisons, i, dt[2];
    // cur, chem, volt, expected state
    logic [18:0] bad [6] = '{{5'h10, 5'h01, 5'h05, 4'hE}, {5'h05, 5'h10, 5'h05, 4'hE},
        {5'h05, 5'h00, 5'h05, 4'hE}, {5'h05, 5'h01, 5'h10, 4'hD}, {5'h05, 5'h05, 5'h01, 4'hD},
        {5'h00, 5'h01, 5'h05, 4'h8}};

    chc_top #(.TICK_DIV(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .power_good(power_good),
        .charge_enable_n(en_n), .charge_current_set_pin(cur), .chemistry_timer_select_pin(chem),
        .regulation_voltage_select_pin(volt), .sense(sense), .drive(drive), .fault(fault),
        .charge_done(done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    chc_batt pack (.lowv(lowv), .sag(sag), .over(over), .hot(hot), .drive(drive), .sense(sense));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] e, s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // sampled at the falling edge so the decision never races the slave's flops
    task automatic rd(input logic [3:0] a);
        int   n;
        logic ar, rv;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge sys_clk);
            ar = arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (ar) arvalid <= 1'b0;
            if (rv) break;
        end
        if (n == 50) chk("read answer", 32'h1, 32'h0);
        if (n == 50) final_report();
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int   n;
        logic aw, w, b;
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(negedge sys_clk);
            aw = awready;
            w = wready;
            b = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) break;
        end
        if (n == 50) chk("write answer", 32'h1, 32'h0);
        if (n == 50) final_report();
    endtask

    task automatic st(input logic [3:0] e);
        rd(REG_STATUS);
        chk("state", 32'(e), 32'(d[3:0]));
    endtask

    task automatic start(input logic [4:0] c, h, v);
        en_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        {cur, chem, volt, en_n} <= {c, h, v, 1'b0};
        repeat (12) @(posedge sys_clk);
    endtask

    initial begin
        {rst_n, en_n, lowv, sag, over, hot, power_good} = 7'h21;
        {cur, chem, volt, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, wstrb} = 9'h00F;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 1; i < 15; i++) begin
            start(5'h05, 5'(i), 5'h05);
            rd(REG_CONFIG);
            if (i == 4) st(4'hD);
            else chk("hours", 32'((i == 1) ? 5 : (i == 2) ? 10 : (i == 3) ? 0 : 2 * i - 6), 32'(d[9:5]));
        end
        for (i = 0; i < 6; i++) begin
            start(bad[i][18:14], bad[i][13:9], bad[i][8:4]);
            st(bad[i][3:0]);
            chk("fault", 32'(bad[i][3:0] == 4'hE), 32'(fault));
        end
        {lowv, sag, power_good} <= 3'h6;
        start(5'h05, 5'h01, 5'h01);
        st(4'h0);
        power_good <= 1'b1;
        repeat (12) @(posedge sys_clk);
        st(4'h5);
        @(negedge sys_clk);
        chk("pct", 32'(PRE_PCT), 32'(drive.current_pct));
        chk("enable", 32'h1, 32'(drive.enable));
        @(posedge sys_clk);
        {lowv, cur} <= {1'b0, 5'h09};
        repeat (4) @(posedge sys_clk);
        chem <= 5'h05;
        st(4'h6);
        @(negedge sys_clk);
        chk("pct", 32'(FULL_PCT), 32'(drive.current_pct));
        chk("code", 32'h9, 32'(drive.current_code));
        chk("vreg", 32'h1, 32'(drive.vreg_code));
        @(posedge sys_clk);
        rd(REG_CONFIG);
        chk("hours", 32'h5, 32'(d[9:5]));
        for (i = 0; i < 2; i++) begin
            hot <= i[0];
            rd(REG_TIMER);
            t0 = d;
            repeat (400) @(posedge sys_clk);
            rd(REG_TIMER);
            dt[i] = int'(d - t0);
        end
        chk("half rate", 32'h1, 32'(dt[1] * 2 >= dt[0] - 3 && dt[1] * 2 <= dt[0] + 3));
        {hot, sag, chem} <= {2'h0, 5'h01};
        repeat (8) @(posedge sys_clk);
        st(4'h8);
        @(negedge sys_clk);
        chk("done", 32'h1, 32'(done));
        chk("enable", 32'h0, 32'(drive.enable));
        @(posedge sys_clk);
        sag <= 1'b1;
        repeat (8) @(posedge sys_clk);
        st(4'h6);
        wr(REG_STATUS, 32'h0000_0001);
        chk("bresp", 32'(RESP_SLVERR), 32'(r));
        rd(4'h2);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        chk("rdata", 32'h0, d);
        wr(REG_CTRL, 32'h0000_0001);
        st(4'h0);
        lowv <= 1'b1;
        wr(REG_CTRL, 32'h0000_0000);
        repeat (12) @(posedge sys_clk);
        st(4'h5);
        repeat (7000) @(posedge sys_clk);
        st(4'h5);
        repeat (300) @(posedge sys_clk);
        st(4'hC);
        lowv <= 1'b0;
        repeat (20) @(posedge sys_clk);
        st(4'hC);
        start(5'h05, 5'h01, 5'h01);
        st(4'h6);
        sag <= 1'b0;
        start(5'h05, 5'h05, 5'h04);
        st(4'h9);
        chk("mode", 32'h3, 32'(d[5:4]));
        sag <= 1'b1;
        repeat (4) @(posedge sys_clk);
        st(4'hA);
        {over, sag} <= 2'h2;
        repeat (4) @(posedge sys_clk);
        st(4'hB);
        {over, sag} <= 2'h1;
        repeat (4) @(posedge sys_clk);
        st(4'hA);
        sag <= 1'b0;
        repeat (14000) @(posedge sys_clk);
        st(4'hA);
        repeat (600) @(posedge sys_clk);
        st(4'hB);
        final_report();
    end
endmodule
`default_nettype wire
